//--- verilog/dbfc_defs.svh
// timing counts, command codes and field constants for the flash command port host
`ifndef DBFC_DEFS_SVH
`define DBFC_DEFS_SVH
`define DBFC_CLK_MHZ 10
`define DBFC_T_ACCESS_NS 70
`define DBFC_ACC_CYC ((`DBFC_T_ACCESS_NS * `DBFC_CLK_MHZ + 999) / 1000 + 1)
`define DBFC_T_WPULSE_NS 100
`define DBFC_WP_CYC ((`DBFC_T_WPULSE_NS * `DBFC_CLK_MHZ + 999) / 1000)
`define DBFC_T_LOWPWR_NS 500
`define DBFC_LP_CYC ((`DBFC_T_LOWPWR_NS * `DBFC_CLK_MHZ) / 1000)
`define DBFC_CMD_SECTOR 8'h50
`define DBFC_CMD_BLOCK 8'h30
`define DBFC_CMD_CHIP 8'h10
`define DBFC_CHIP_ADDR 21'h000555
`define DBFC_UNLK_A1 21'h000555
`define DBFC_UNLK_D1 8'hAA
`define DBFC_UNLK_A2 21'h0002AA
`define DBFC_UNLK_D2 8'h55
`define DBFC_PRG_D3 8'hA0
`define DBFC_ERS_D3 8'h80
`define DBFC_POLL_BIT 7
`define DBFC_TOGGLE_BIT 6
`define DBFC_SECTOR_WORDS 2048
`define DBFC_BLOCK_WORDS 32768
`endif

//--- verilog/dbfc_pkg.sv
// types for the flash command port host
package dbfc_pkg;
  typedef enum logic [2:0] {
    DBFC_OP_READ = 3'h0,
    DBFC_OP_PROG = 3'h1,
    DBFC_OP_SECTOR = 3'h2,
    DBFC_OP_BLOCK = 3'h3,
    DBFC_OP_CHIP = 3'h4
  } dbfc_op_e;
  typedef struct packed {
    dbfc_op_e op;
    logic [20:0] addr;
    logic [15:0] data;
  } dbfc_req_s;
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
  } dbfc_ctl_s;
  typedef enum logic [6:0] {
    DBFC_IDLE = 7'h01,
    DBFC_SETUP = 7'h02,
    DBFC_STRB = 7'h04,
    DBFC_GAP = 7'h08,
    DBFC_RSTRB = 7'h10,
    DBFC_POLL = 7'h20,
    DBFC_DONE = 7'h40
  } dbfc_state_e;
endpackage : dbfc_pkg

//--- verilog/dbfc_host.sv
// host-side sequencer driving a dual-bank nor flash through its command pins
`timescale 1ns/1ps
`include "dbfc_defs.svh"
module dbfc_host
  import dbfc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // user request
  input wire logic i_req_valid,
  input wire dbfc_req_s i_req,
  input wire logic i_byte_mode,
  input wire logic i_protect_n,
  output logic o_req_ready,
  output logic o_done,
  output logic o_refused,
  output logic [15:0] o_rdata,
  // flash pins
  output dbfc_ctl_s o_ctl,
  output logic [20:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in,
  output logic o_word_n,
  output logic o_protect_n
);
  localparam logic [3:0] WP_CYC = 4'(`DBFC_WP_CYC);
  localparam logic [3:0] ACC_CYC = 4'(`DBFC_ACC_CYC);

  dbfc_state_e state;
  dbfc_state_e next_state;
  dbfc_req_s cur;
  logic [2:0] cyc;
  logic [3:0] cnt;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [15:0] last_rd;
  logic have_last;
  logic word_mode;

  // unlock table: fixed AA/55 pair, per-op A0/80 setup code, then per-op final cycle
  function automatic logic [36:0] wr_cycle(input dbfc_op_e op, input logic [2:0] n,
                                          input logic [20:0] a, input logic [15:0] d);
    logic [36:0] r;
    r = {`DBFC_UNLK_A1, 8'h00, `DBFC_UNLK_D1};
    if (n == 3'h1 || n == 3'h4) begin
      r = {`DBFC_UNLK_A2, 8'h00, `DBFC_UNLK_D2};
    end else if (n == 3'h2) begin
      r = {`DBFC_UNLK_A1, 8'h00, (op == DBFC_OP_PROG) ? `DBFC_PRG_D3 : `DBFC_ERS_D3};
    end else if (op == DBFC_OP_PROG && n == 3'h3) begin
      r = {a, d};
    end else if (n == 3'h5) begin
      if (op == DBFC_OP_SECTOR) begin
        r = {a, 8'h00, `DBFC_CMD_SECTOR};
      end else if (op == DBFC_OP_BLOCK) begin
        r = {a, 8'h00, `DBFC_CMD_BLOCK};
      end else begin
        r = {`DBFC_CHIP_ADDR, 8'h00, `DBFC_CMD_CHIP};
      end
    end
    return r;
  endfunction : wr_cycle

  wire is_write = (cur.op != DBFC_OP_READ);
  wire [2:0] last_cyc = (cur.op == DBFC_OP_PROG) ? 3'h3 : 3'h5;
  // next write cycle: cyc still holds the finished one when GAP hands over to SETUP
  wire [36:0] wc = wr_cycle(cur.op, cyc + 3'h1, cur.addr, cur.data);
  // first cycle comes from the request itself, since cur loads on that same edge
  wire [36:0] wc_first = wr_cycle(i_req.op, 3'h0, i_req.addr, i_req.data);
  wire cnt_done = (cnt == 4'h0);
  wire chip_block = (i_req.op == DBFC_OP_CHIP) && !i_protect_n;
  wire [15:0] rd_mask = word_mode ? 16'hFFFF : 16'h00FF;
  wire [15:0] rd_now = dq_s2 & rd_mask;
  // completion: two equal status reads, poll bit true or one for erase
  wire poll_ok = (cur.op == DBFC_OP_PROG) ?
                 (rd_now[`DBFC_POLL_BIT] == cur.data[`DBFC_POLL_BIT]) :
                 rd_now[`DBFC_POLL_BIT];
  wire settled = have_last && (last_rd == rd_now) && poll_ok;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      DBFC_IDLE: begin
        if (i_req_valid && !chip_block) begin
          next_state = DBFC_SETUP;
        end
      end
      DBFC_SETUP: begin
        next_state = is_write ? DBFC_STRB : DBFC_RSTRB;
      end
      DBFC_STRB: begin
        if (cnt_done) begin
          next_state = DBFC_GAP;
        end
      end
      DBFC_GAP: begin
        if (cyc != last_cyc) begin
          next_state = DBFC_SETUP;
        end else begin
          next_state = DBFC_POLL;
        end
      end
      DBFC_RSTRB: begin
        if (cnt_done) begin
          next_state = (is_write && !settled) ? DBFC_POLL : DBFC_DONE;
        end
      end
      DBFC_POLL: begin
        next_state = DBFC_RSTRB;
      end
      DBFC_DONE: begin
        next_state = DBFC_IDLE;
      end
      default: begin
        next_state = DBFC_IDLE;
      end
    endcase
  end

  // state, counters and request capture
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= DBFC_IDLE;
      cur <= '0;
      cyc <= 3'h0;
      cnt <= 4'h0;
      word_mode <= 1'b1;
    end else begin
      state <= next_state;
      if (state == DBFC_IDLE && i_req_valid) begin
        cur <= i_req;
        word_mode <= !i_byte_mode;
        cyc <= 3'h0;
      end
      if (state == DBFC_GAP) begin
        cyc <= cyc + 3'h1;
      end
      if (next_state == DBFC_STRB && state != DBFC_STRB) begin
        cnt <= WP_CYC - 4'h1;
      end else if (next_state == DBFC_RSTRB && state != DBFC_RSTRB) begin
        cnt <= ACC_CYC; // extra cycle: read data crosses two synchroniser stages
      end else if (!cnt_done) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  // data input synchroniser; device data is asynchronous
  always_ff @(posedge i_clk) begin
    dq_s1 <= i_dq_in;
    dq_s2 <= dq_s1;
  end

  // status read history for toggle detection
  always_ff @(posedge i_clk) begin
    if (i_reset || state == DBFC_IDLE) begin
      have_last <= 1'b0;
      last_rd <= 16'h0000;
    end else if (state == DBFC_RSTRB && cnt_done) begin
      have_last <= 1'b1;
      last_rd <= rd_now;
    end
  end

  // pin drive: address held across the whole strobe, data until after rise
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ctl <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      o_addr <= 21'h000000;
      o_dq_out <= 16'h0000;
      o_dq_oe <= 1'b0;
    end else begin
      o_ctl.cs_n <= !(next_state == DBFC_SETUP || next_state == DBFC_STRB ||
                      next_state == DBFC_RSTRB);
      o_ctl.we_n <= !(next_state == DBFC_STRB);
      o_ctl.oe_n <= !(next_state == DBFC_RSTRB);
      if (next_state == DBFC_SETUP && state == DBFC_IDLE) begin
        o_addr <= (i_req.op != DBFC_OP_READ) ? wc_first[36:16] : i_req.addr;
        o_dq_out <= wc_first[15:0];
      end else if (next_state == DBFC_SETUP) begin
        o_addr <= wc[36:16];
        o_dq_out <= wc[15:0];
      end
      if (state == DBFC_POLL || (state == DBFC_GAP && next_state == DBFC_POLL)) begin
        o_addr <= cur.addr; // poll the busy bank location
      end
      o_dq_oe <= (next_state == DBFC_SETUP && is_write && state != DBFC_IDLE) ||
                 (next_state == DBFC_SETUP && state == DBFC_IDLE &&
                  i_req.op != DBFC_OP_READ) ||
                 next_state == DBFC_STRB ||
                 next_state == DBFC_GAP; // data held past the strobe rise
    end
  end

  // user side: one operation at a time, nothing issued while busy
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_req_ready <= 1'b1;
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_rdata <= 16'h0000;
      o_word_n <= 1'b1;
      o_protect_n <= 1'b1;
    end else begin
      o_req_ready <= (next_state == DBFC_IDLE);
      o_done <= (state == DBFC_DONE);
      o_refused <= (state == DBFC_IDLE) && i_req_valid && chip_block;
      o_protect_n <= i_protect_n;
      o_word_n <= (state == DBFC_IDLE) ? !i_byte_mode : word_mode;
      if (state == DBFC_RSTRB && cnt_done) begin
        o_rdata <= rd_now;
      end
    end
  end
endmodule : dbfc_host

//--- sim/dbfc_flash_model.sv
// behavioural flash device answering the host's command pins
`timescale 1ns/1ps
module dbfc_flash_model
  import dbfc_pkg::*;
#(parameter int PRG_NS = 7000, parameter int ERS_NS = 20000)
(
  // pins from the host
  input wire dbfc_ctl_s i_ctl,
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_protect_n,
  // data back to the host
  output logic [15:0] o_dq
);
  logic [15:0] mem [int];
  logic [15:0] cmd [7];
  logic [20:0] a;
  logic [15:0] pd = 16'h0000;
  logic [15:0] q;
  logic busy = 0;
  logic ers = 0;
  logic tg = 0;
  int n = 0;
  wire wr = !i_ctl.cs_n && !i_ctl.we_n;
  wire rd = !i_ctl.cs_n && !i_ctl.oe_n;
  // address taken when the later of select and strobe falls
  always @(posedge wr) a = i_addr;
  // data and command taken on the first rise; busy swallows commands
  always @(negedge wr) begin
    if (!busy) begin
      n++;
      cmd[n] = i_dq;
      if (cmd[1][7:0] !== 8'hAA) n = 0;
      if (n == 4 && cmd[3][7:0] == 8'hA0) begin
        pd = i_dq;
        mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & i_dq;
        ers = 0;
        busy = 1;
        n = 0;
      end
      if (n == 6) begin
        if (i_dq[7:0] != 8'h10 || i_protect_n) begin
          foreach (mem[k])
            if (i_dq[7:0] == 8'h10 || (i_dq[7:0] == 8'h50 ? k[20:11] == a[20:11] :
                k[20:15] == a[20:15]))
              mem[k] = 16'hFFFF;
          ers = 1;
          busy = 1;
        end
        n = 0;
      end
      if (busy) fork #(ers ? ERS_NS : PRG_NS) busy = 0; join_none
    end
  end
  // toggle flips on every read started while busy
  always @(posedge rd) if (busy) tg = !tg;
  // status only while busy; released bus shows the inverse, not old data
  always @(i_addr or rd or busy or tg or ers) begin
    if (busy) q = {!ers && !pd[7], tg, 14'h0000};
    else q = mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
    o_dq = rd ? q : ~q;
  end
endmodule : dbfc_flash_model

//--- sim/dbfc_host_asserts.sv
// checker on the host's ports: framing, gating and sequence counts
`timescale 1ns/1ps
module dbfc_host_asserts
  import dbfc_pkg::*;
(
  // watched ports
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire dbfc_req_s i_req,
  input wire logic i_protect_n,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire logic o_refused,
  input wire dbfc_ctl_s o_ctl,
  input wire logic [20:0] o_addr,
  input wire logic [15:0] o_dq_out,
  input wire logic o_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  dbfc_op_e op;
  logic [3:0] wcnt;
  wire take = i_req_valid && o_req_ready;
  wire [3:0] n_exp = op == DBFC_OP_READ ? 4'h0 : op == DBFC_OP_PROG ? 4'h4 : 4'h6;
  wire [7:0] last = op == DBFC_OP_SECTOR ? 8'h50 : op == DBFC_OP_BLOCK ? 8'h30 : 8'h10;
  // strobes counted from each accepted request
  always_ff @(posedge i_clk) begin
    if (take) op <= i_req.op;
    if (i_reset || take) wcnt <= 4'h0;
    else if ($fell(o_ctl.we_n)) wcnt <= wcnt + 4'h1;
  end
  sequence s_lock;
    take && i_req.op == DBFC_OP_CHIP && !i_protect_n;
  endsequence
  sequence s_read;
    take && i_req.op == DBFC_OP_READ;
  endsequence
  wr_frame_a: assert property (!o_ctl.we_n |-> !o_ctl.cs_n && o_ctl.oe_n && o_dq_oe)
    else $error("strobe outside a write");
  addr_settle_a: assert property ($fell(o_ctl.we_n) |-> $stable(o_addr))
    else $error("address moved at strobe");
  data_hold_a: assert property ($rose(o_ctl.we_n) |-> o_dq_oe && $stable(o_dq_out))
    else $error("data moved at strobe rise");
  rd_gate_a: assert property (!o_ctl.oe_n |-> !o_dq_oe && o_ctl.we_n)
    else $error("bus fight on read");
  idle_desel_a: assert property (o_req_ready |-> o_ctl.cs_n)
    else $error("selected while idle");
  strobe_count_a: assert property (o_done |-> wcnt == n_exp)
    else $error("wrong strobe count");
  final_cmd_a: assert property ($rose(o_ctl.we_n) && wcnt == 4'h6 |->
    o_dq_out[7:0] == last && (op != DBFC_OP_CHIP || o_addr == 21'h000555))
    else $error("wrong final erase cycle");
  lock_refuse_a: assert property (s_lock |=> o_ctl.cs_n throughout (##[0:1] o_refused))
    else $error("locked erase not refused");
  read_start_a: assert property (s_read |=> ##[0:3] !o_ctl.oe_n)
    else $error("read slow to start");
endmodule : dbfc_host_asserts
bind dbfc_host dbfc_host_asserts chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_req_valid(i_req_valid), .i_req(i_req), .i_protect_n(i_protect_n),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_refused(o_refused), .o_ctl(o_ctl),
  .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));

//--- sim/dbfc_host_bench.sv
// self-checking bench: host sequencer against a behavioural flash
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module dbfc_host_bench
  import dbfc_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  logic valid = 0;
  logic prot = 1;
  logic byte_m = 0;
  dbfc_req_s req = '0;
  logic done, ready, refused, dq_oe, word_n, prot_o;
  logic [15:0] rdata, dq_out, dq_in;
  logic [20:0] addr;
  logic [20:0] al [3];
  dbfc_ctl_s ctl;
  logic [15:0] exp_mem [int];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 clk = !clk;
  dbfc_host dut_u (.i_clk(clk), .i_reset(rst), .i_req_valid(valid), .i_req(req),
    .i_byte_mode(byte_m), .i_protect_n(prot), .o_req_ready(ready), .o_done(done),
    .o_refused(refused), .o_rdata(rdata), .o_ctl(ctl), .o_addr(addr), .o_dq_out(dq_out),
    .o_dq_oe(dq_oe), .i_dq_in(dq_in), .o_word_n(word_n), .o_protect_n(prot_o));
  dbfc_flash_model flash_u (.i_ctl(ctl), .i_addr(addr), .i_dq(dq_out),
    .i_protect_n(prot_o), .o_dq(dq_in));
  function automatic logic [15:0] ev(input logic [20:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 16'hFFFF;
  endfunction : ev
  // one request; the wait is bounded so a stuck host cannot hang here
  task automatic run(input dbfc_op_e o, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req = '{op: o, addr: a, data: d};
    valid = 1;
    @(posedge clk);
    #1;
    valid = 0;
    while (!done && !refused && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(1'(done || refused), 1'b1)
    `CHK(ready, 1'b1)
  endtask : run
  task automatic rd_chk(input logic [20:0] a);
    run(DBFC_OP_READ, a, 16'h0000);
    `CHK(rdata, ev(a) & (byte_m ? 16'h00FF : 16'hFFFF))
  endtask : rd_chk
  task automatic erase(input dbfc_op_e o, input logic [20:0] a);
    run(o, a, 16'h0000);
    `CHK(refused, 1'(o == DBFC_OP_CHIP && !prot))
    `CHK(prot_o, prot)
    foreach (exp_mem[k])
      if (o == DBFC_OP_CHIP ? prot : o == DBFC_OP_SECTOR ? k[20:11] == a[20:11] :
          k[20:15] == a[20:15])
        exp_mem[k] = 16'hFFFF;
  endtask : erase
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // main sequence: program, erase at each granularity, locked chip erase
  initial begin
    void'($urandom(32'h7b73bbf6));
    al[0] = 21'h010000 | 21'($urandom_range(2047));
    al[1] = al[0] + 21'h000800;
    al[2] = 21'h1F0000 | 21'($urandom_range(65535));
    repeat (5) @(posedge clk);
    #1;
    `CHK(ctl, 3'h7)
    rst = 0;
    `CHK(word_n, 1'b1)
    foreach (al[i]) begin
      req.data = 16'($urandom);
      run(DBFC_OP_PROG, al[i], req.data);
      exp_mem[al[i]] = req.data; // programmed word expected back; untouched locations read as erased
      rd_chk(al[i]);
    end
    erase(DBFC_OP_SECTOR, al[0]);
    rd_chk(al[0]);
    rd_chk(al[1]);
    erase(DBFC_OP_BLOCK, al[1]);
    rd_chk(al[1]);
    rd_chk(al[2]);
    prot = 0;
    erase(DBFC_OP_CHIP, al[2]);
    rd_chk(al[2]);
    prot = 1;
    erase(DBFC_OP_CHIP, al[2]);
    rd_chk(al[2]);
    byte_m = 1;
    rd_chk(al[2]);
    `CHK(word_n, 1'b0)
    complete_run;
  end
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
endmodule : dbfc_host_bench
